// *** sarrd_ctrl.sv ***
// Conversion start, mode selection and serial result readout of an
// 18-bit successive-approximation converter.
// Assumes pins arrive asynchronously and are sampled by clk_i; the
// serial data pin is a value and an enable, resolved outside.
// Pin edges are seen about three clock cycles late, so host pin
// half periods of three cycles or more are assumed.
`timescale 1ns/1ns
module sarrd_ctrl #(
    parameter int unsigned CONV_CYCLES = sarrd_pkg::CONV_CYCLES
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic convert_start_i,
    input wire logic mode_select_in_i,
    input wire logic sclk_i,
    input wire logic signed [sarrd_pkg::RAW_W-1:0] raw_code_i,
    output logic serial_data_out_o,
    output logic serial_data_out_oe_o,
    output logic sample_o,
    output logic converting_o,
    output logic powered_down_o
);

    // ------------------------------------------------------------
    // Pin sampling
    // ------------------------------------------------------------
    logic [sarrd_pkg::PIN_CNT-1:0] pins_s;
    logic cnv_d;
    logic sel_d;
    logic sck_d;

    sarrd_sync u_sync (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .pins_i({sclk_i, mode_select_in_i, convert_start_i}),
        .pins_o(pins_s)
    );

    wire convert_start = pins_s[sarrd_pkg::PIN_CNV];
    wire sel = pins_s[sarrd_pkg::PIN_SEL];
    wire sck = pins_s[sarrd_pkg::PIN_SCK];

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnv_d <= 1'b0;
            sel_d <= 1'b0;
            sck_d <= 1'b0;
        end else begin
            cnv_d <= convert_start;
            sel_d <= sel;
            sck_d <= sck;
        end
    end

    // ------------------------------------------------------------
    // Edge decode
    // ------------------------------------------------------------
    wire cnv_rise = convert_start && !cnv_d;
    wire sck_fall = !sck && sck_d;
    // Device is addressed while either convert or select is low
    wire pick = !(convert_start && sel);
    wire pick_d = !(cnv_d && sel_d);
    wire pick_fall = pick && !pick_d;
    wire pick_rise = !pick && pick_d;
    wire both_low = !convert_start && !sel;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    sarrd_pkg::sarrd_state_t state;
    sarrd_pkg::sarrd_state_t next_state;
    logic cs_mode;
    logic next_cs_mode;
    logic chain_busy;
    logic next_chain_busy;
    logic busy_bit;
    logic next_busy_bit;
    logic [sarrd_pkg::RES_W-1:0] shreg;
    logic [sarrd_pkg::RES_W-1:0] next_shreg;
    logic [4:0] falls;
    logic [4:0] next_falls;
    logic serial_data_out;
    logic next_sdo;
    logic oe;
    logic next_oe;

    logic conv_busy;
    logic conv_done;
    logic [sarrd_pkg::RES_W-1:0] conv_code;

    // ------------------------------------------------------------
    // Start decode
    // ------------------------------------------------------------
    // A start is honoured outside conversion only; a new rise during
    // a conversion is ignored so the running one completes.
    wire start = cnv_rise && (state != sarrd_pkg::ST_CONV);
    // Select level before the edge, so tying it to convert reads low
    wire start_cs = sel_d;
    wire start_busy = sck_d;
    // Busy choice in selected mode is made when the result appears
    wire end_busy = !convert_start || !sel;
    wire [4:0] fall_limit =
        busy_bit ? sarrd_pkg::FALLS_BUSY : sarrd_pkg::FALLS_PLAIN;
    wire [4:0] falls_inc = falls + sarrd_pkg::FALL_CNT_ONE;
    wire last_fall = falls_inc == fall_limit;
    // In chain mode the select pin feeds the shift register
    wire [sarrd_pkg::RES_W-1:0] shifted =
        {shreg[sarrd_pkg::RES_W-2:0], cs_mode ? 1'b0 : sel};

    // ------------------------------------------------------------
    // Conversion-end and frame decisions
    // ------------------------------------------------------------
    // Selected mode with convert or select low at the end: busy bit
    wire end_sel_busy = cs_mode && end_busy;
    // Selected mode otherwise waits to be addressed
    wire end_sel_wait = cs_mode && !end_busy;
    // First chain bit is the busy bit or the result MSB
    wire chain_first = chain_busy ? 1'b1 : conv_code[sarrd_pkg::RES_W-1];
    // Without busy the MSB is already on the pin, so load it shifted
    wire [sarrd_pkg::RES_W-1:0] chain_load = chain_busy ? conv_code :
        {conv_code[sarrd_pkg::RES_W-2:0], 1'b0};
    // Convert or select rising ends a selected-mode frame
    wire sel_frame_end = cs_mode && pick_rise;
    // A chain frame ends once convert is low
    wire chain_frame_end = !cs_mode && !convert_start;
    // Both pins low in a selected frame: drive low and stop
    wire sel_both_low = cs_mode && both_low;
    // Last counted falling edge ends a selected-mode frame
    wire sel_last_fall = cs_mode && last_fall;

    sarrd_conv_timer #(
        .CONV_CYCLES(CONV_CYCLES)
    ) u_timer (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .start_i(start),
        .raw_i(raw_code_i),
        .busy_o(conv_busy),
        .done_o(conv_done),
        .code_o(conv_code)
    );

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_cs_mode = cs_mode;
        next_chain_busy = chain_busy;
        next_busy_bit = busy_bit;
        next_shreg = shreg;
        next_falls = falls;
        next_sdo = serial_data_out;
        next_oe = oe;
        if (start) begin
            next_state = sarrd_pkg::ST_CONV;
            next_cs_mode = start_cs;
            next_chain_busy = start_busy;
            next_busy_bit = 1'b0;
            next_oe = 1'b0;
            next_sdo = 1'b0;
        end else begin
            unique case (state)
                sarrd_pkg::ST_ACQ: begin
                    // Idle: drive low when both pins are low
                    next_oe = both_low;
                    next_sdo = 1'b0;
                end
                sarrd_pkg::ST_CONV: begin
                    // Output stays floating whatever convert does
                    next_oe = 1'b0;
                    if (conv_done) begin
                        next_shreg = conv_code;
                        next_falls = '0;
                        if (end_sel_busy) begin
                            next_busy_bit = 1'b1;
                            next_oe = 1'b1;
                            next_sdo = 1'b0;
                            next_state = sarrd_pkg::ST_READ;
                        end else if (end_sel_wait) begin
                            // Wait for the host to address us
                            next_state = sarrd_pkg::ST_WAIT;
                        end else begin
                            next_busy_bit = chain_busy;
                            next_oe = 1'b1;
                            next_sdo = chain_first;
                            next_shreg = chain_load;
                            next_state = sarrd_pkg::ST_READ;
                        end
                    end
                end
                sarrd_pkg::ST_WAIT: begin
                    next_oe = both_low;
                    next_sdo = 1'b0;
                    if (pick_fall) begin
                        // MSB appears as soon as the device is picked
                        next_sdo = shreg[sarrd_pkg::RES_W-1];
                        next_shreg = shifted;
                        next_oe = 1'b1;
                        next_state = sarrd_pkg::ST_READ;
                    end
                end
                sarrd_pkg::ST_READ: begin
                    if (sel_frame_end) begin
                        // Convert or select rising ends the frame
                        next_oe = 1'b0;
                        next_state = sarrd_pkg::ST_ACQ;
                    end else if (sel_both_low) begin
                        next_oe = 1'b1;
                        next_sdo = 1'b0;
                        next_state = sarrd_pkg::ST_ACQ;
                    end else if (chain_frame_end) begin
                        // Chain frame ends with convert low
                        next_oe = both_low;
                        next_sdo = 1'b0;
                        next_state = sarrd_pkg::ST_ACQ;
                    end else if (sck_fall) begin
                        next_falls = falls_inc;
                        if (sel_last_fall) begin
                            next_oe = 1'b0;
                            next_state = sarrd_pkg::ST_ACQ;
                        end else begin
                            // Bit changes only on a falling edge, so it
                            // holds across the following rising edge
                            next_sdo = shreg[sarrd_pkg::RES_W-1];
                            next_shreg = shifted;
                        end
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Registers, one short process each
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state <= sarrd_pkg::ST_ACQ;
        end else begin
            state <= next_state;
        end
    end

    // Reset picks the selected mode, the usual single-device use
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cs_mode <= 1'b1;
        end else begin
            cs_mode <= next_cs_mode;
        end
    end

    // Chain busy choice, fixed at the start of a conversion
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            chain_busy <= 1'b0;
        end else begin
            chain_busy <= next_chain_busy;
        end
    end

    // Busy start bit of the current frame
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            busy_bit <= 1'b0;
        end else begin
            busy_bit <= next_busy_bit;
        end
    end

    // Result shift register
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            shreg <= '0;
        end else begin
            shreg <= next_shreg;
        end
    end

    // Falling edges counted in the current frame
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            falls <= '0;
        end else begin
            falls <= next_falls;
        end
    end

    // Pin value changes only on a decoded pin edge or at the conversion end, never mid-bit
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            serial_data_out <= 1'b0;
        end else begin
            serial_data_out <= next_sdo;
        end
    end

    // Pin enable; low lets the line float
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            oe <= 1'b0;
        end else begin
            oe <= next_oe;
        end
    end

    // Start pulse, one cycle after the start is taken
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sample_o <= 1'b0;
        end else begin
            sample_o <= start;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign serial_data_out_o = serial_data_out;
    assign serial_data_out_oe_o = oe;
    assign converting_o = conv_busy;
    // Core sleeps whenever no conversion runs
    assign powered_down_o = !conv_busy;

endmodule

// *** sarrd_pkg.sv ***
// Shared constants of the converter start and serial readout logic.
// Assumes a 125 MHz system clock; all pins are sampled by that clock.
package sarrd_pkg;

    // ------------------------------------------------------------
    // Clock and conversion timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 8;
    // Plain defaults; the true limits are not known to this block
    localparam int unsigned T_CONV_MIN_NS = 500;
    localparam int unsigned T_CONV_MAX_NS = 710;
    localparam int unsigned T_CONV_NS = 600;
    // Nominal time T_CONV_NS, rounded up to whole cycles
    localparam int unsigned CONV_CYCLES =
        (T_CONV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned CONV_CNT_W = 12;

    // ------------------------------------------------------------
    // Result word
    // ------------------------------------------------------------
    localparam int unsigned RES_W = 18;
    localparam int unsigned RAW_W = 20;
    localparam logic [17:0] CODE_POS_FS = 18'h1FFFF;
    localparam logic [17:0] CODE_NEG_FS = 18'h20000;
    localparam logic signed [19:0] RAW_POS_LIM = 20'sh1FFFF;
    localparam logic signed [19:0] RAW_NEG_LIM = -20'sh20000;

    // ------------------------------------------------------------
    // Readout framing
    // ------------------------------------------------------------
    localparam logic [4:0] FALLS_PLAIN = 5'h12;
    localparam logic [4:0] FALLS_BUSY = 5'h13;
    localparam logic [4:0] FALL_CNT_ONE = 5'h01;

    // ------------------------------------------------------------
    // Pin synchroniser
    // ------------------------------------------------------------
    localparam int unsigned PIN_CNT = 3;
    localparam int unsigned PIN_CNV = 0;
    localparam int unsigned PIN_SEL = 1;
    localparam int unsigned PIN_SCK = 2;

    typedef enum logic [1:0] {
        ST_ACQ,
        ST_CONV,
        ST_WAIT,
        ST_READ
    } sarrd_state_t;

endpackage

// *** sarrd_sync.sv ***
// Two-flop synchronisers for the asynchronous host pins.
// Assumes the pins come from a domain unrelated to clk_i.
`timescale 1ns/1ns
module sarrd_sync (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic [sarrd_pkg::PIN_CNT-1:0] pins_i,
    output logic [sarrd_pkg::PIN_CNT-1:0] pins_o
);
    logic [sarrd_pkg::PIN_CNT-1:0] meta;

    // ------------------------------------------------------------
    // One chain per pin
    // ------------------------------------------------------------
    for (genvar i = 0; i < sarrd_pkg::PIN_CNT; i++) begin : g_pin
        always_ff @(posedge clk_i or negedge rstn_i) begin
            if (!rstn_i) begin
                meta[i] <= 1'b0;
                pins_o[i] <= 1'b0;
            end else begin
                meta[i] <= pins_i[i];
                pins_o[i] <= meta[i];
            end
        end
    end
endmodule

// *** sarrd_conv_timer.sv ***
// Conversion timer: times one conversion from the system clock
// and captures the clamped result when it ends.
// Assumes start_i is a one-cycle pulse from the readout control.
`timescale 1ns/1ns
module sarrd_conv_timer #(
    parameter int unsigned CONV_CYCLES = sarrd_pkg::CONV_CYCLES
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic start_i,
    input wire logic signed [sarrd_pkg::RAW_W-1:0] raw_i,
    output logic busy_o,
    output logic done_o,
    output logic [sarrd_pkg::RES_W-1:0] code_o
);
    localparam logic [sarrd_pkg::CONV_CNT_W-1:0] LAST =
        sarrd_pkg::CONV_CNT_W'(CONV_CYCLES - 1);

    logic [sarrd_pkg::CONV_CNT_W-1:0] cnt;
    wire at_end = busy_o && (cnt == LAST);
    wire over = raw_i > sarrd_pkg::RAW_POS_LIM;
    wire under = raw_i < sarrd_pkg::RAW_NEG_LIM;
    wire [sarrd_pkg::RES_W-1:0] clamped =
        over ? sarrd_pkg::CODE_POS_FS :
        under ? sarrd_pkg::CODE_NEG_FS :
        raw_i[sarrd_pkg::RES_W-1:0];

    // ------------------------------------------------------------
    // Own clock times the conversion; serial clock not needed
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            busy_o <= 1'b0;
            cnt <= '0;
            done_o <= 1'b0;
            code_o <= '0;
        end else begin
            done_o <= at_end;
            if (start_i && !busy_o) begin
                busy_o <= 1'b1;
                cnt <= '0;
            end else if (at_end) begin
                busy_o <= 1'b0;
                code_o <= clamped;
            end else if (busy_o) begin
                cnt <= cnt + 1'b1;
            end
        end
    end
endmodule

// *** sarrd_ctrl_monitor.sv ***
// Checker for the convert start and serial readout control.
// Assumes it is bound to every sarrd_ctrl and sees only its ports.
`timescale 1ns/1ns
module sarrd_ctrl_monitor #(
    parameter int unsigned CONV_CYCLES = sarrd_pkg::CONV_CYCLES
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic convert_start_i,
    input wire logic mode_select_in_i,
    input wire logic sclk_i,
    input wire logic signed [sarrd_pkg::RAW_W-1:0] raw_code_i,
    input wire logic serial_data_out_o,
    input wire logic serial_data_out_oe_o,
    input wire logic sample_o,
    input wire logic converting_o,
    input wire logic powered_down_o
);
    logic [11:0] conv_cnt;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rstn_i);

    // ------------------------------------------------------------
    // Conversion length counter
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            conv_cnt <= 12'h000;
        end else if (sample_o) begin
            conv_cnt <= 12'h001;
        end else if (converting_o) begin
            conv_cnt <= conv_cnt + 12'h001;
        end
    end

    // Pins pass the synchroniser, so a few samples of margin
    sequence s_both_low;
        (!convert_start_i && !mode_select_in_i && !converting_o)[*6];
    endsequence

    sequence s_sclk_quiet;
        (sclk_i && powered_down_o && $stable(convert_start_i)
            && $stable(mode_select_in_i))[*5];
    endsequence

    start_float_a:
    assert property (sample_o |-> converting_o && !serial_data_out_oe_o)
        else $error("start did not float the data line");
    sample_pulse_a:
    assert property (sample_o |=> !sample_o)
        else $error("sample pulse longer than one cycle");
    conv_float_a:
    assert property (converting_o |-> !serial_data_out_oe_o)
        else $error("data line driven during conversion");
    power_down_a:
    assert property (powered_down_o != converting_o)
        else $error("power-down not inverse of converting");
    conv_len_a:
    assert property ($fell(converting_o) |-> conv_cnt >= CONV_CYCLES - 1
        && conv_cnt <= CONV_CYCLES + 1)
        else $error("conversion length off");
    no_restart_a:
    assert property (sample_o |-> !$past(converting_o))
        else $error("start taken during conversion");
    both_low_a:
    assert property (s_both_low |-> serial_data_out_oe_o
        && !serial_data_out_o)
        else $error("both pins low but line not driven low");
    rise_float_a:
    assert property ($rose(convert_start_i) && serial_data_out_oe_o
        |-> ##[1:6] !serial_data_out_oe_o)
        else $error("convert rise did not float the line");
    bit_hold_a:
    assert property (s_sclk_quiet |-> $stable(serial_data_out_o))
        else $error("data bit changed while serial clock high");
endmodule

bind sarrd_ctrl sarrd_ctrl_monitor #(.CONV_CYCLES(CONV_CYCLES)) u_mon (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .convert_start_i(convert_start_i),
    .mode_select_in_i(mode_select_in_i),
    .sclk_i(sclk_i),
    .raw_code_i(raw_code_i),
    .serial_data_out_o(serial_data_out_o),
    .serial_data_out_oe_o(serial_data_out_oe_o),
    .sample_o(sample_o),
    .converting_o(converting_o),
    .powered_down_o(powered_down_o)
);

// *** sarrd_host.sv ***
// Host model: drives convert, select and serial clock, reads the line.
// Assumes the bench resolves the data line with a pull-up.
`timescale 1ns/1ns
module sarrd_host (
    input wire logic clk_i,
    input wire logic sdo_line_i,
    output logic convert_start_o,
    output logic mode_select_in_o,
    output logic sclk_o
);
    // 80 ns half period of the serial clock at 8 ns per cycle
    localparam int HALF = 10;
    localparam int CONV_WAIT = 30;

    initial begin
        convert_start_o = 1'b0;
        mode_select_in_o = 1'b0;
        sclk_o = 1'b0;
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    task automatic pins(input logic convert_start, input logic sel);
        convert_start_o = convert_start;
        mode_select_in_o = sel;
    endtask

    task automatic sclk_level(input logic lvl);
        sclk_o = lvl;
    endtask

    // Pins held as set for 30 cycles, past the bench's short conversion
    task automatic conv_wait;
        cyc(CONV_WAIT);
    endtask

    // Samples late in the high phase, well after the last fall
    task automatic shift(input int n, output logic [18:0] v);
        v = 19'h00000;
        for (int i = 0; i < n; i++) begin
            sclk_o = 1'b1;
            cyc(HALF);
            v = {v[17:0], sdo_line_i};
            sclk_o = 1'b0;
            cyc(HALF);
        end
    endtask
endmodule

// *** sarrd_ctrl_tb.sv ***
// Self-checking bench for the convert start and serial readout control.
// Assumes the host model drives the pins; the line has a pull-up.
`timescale 1ns/1ns
module sarrd_ctrl_tb;
    localparam int unsigned CONV_SHORT = 4;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic signed [19:0] raw = 20'sh00000;
    logic serial_data_out, sdo_oe, sample, converting, powered_down;
    logic [18:0] v;
    wire logic convert_start, sel, sck, sdo_line;
    int n_mismatch = 0;
    int check_count = 0;

    always #4 clk = ~clk;
    assign sdo_line = sdo_oe ? serial_data_out : 1'b1;

    sarrd_ctrl #(.CONV_CYCLES(CONV_SHORT)) uut (.clk_i(clk),
        .rstn_i(rst_n), .convert_start_i(convert_start), .mode_select_in_i(sel),
        .sclk_i(sck), .raw_code_i(raw), .serial_data_out_o(serial_data_out),
        .serial_data_out_oe_o(sdo_oe), .sample_o(sample),
        .converting_o(converting), .powered_down_o(powered_down));
    sarrd_host host (.clk_i(clk), .sdo_line_i(sdo_line),
        .convert_start_o(convert_start), .mode_select_in_o(sel), .sclk_o(sck));

    function automatic logic [17:0] b(input logic x);
        return {17'h00000, x};
    endfunction

    function automatic logic [17:0] clamp(input logic signed [19:0] r);
        if (r > 20'sh1FFFF) return 18'h1FFFF;
        if (r < -20'sh20000) return 18'h20000;
        return r[17:0];
    endfunction

    task automatic check(input logic [17:0] seen, input logic [17:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic t_plain;
        raw = 20'sh3FFFF;
        // Select must stand high before the convert rise
        host.pins(1'b0, 1'b1);
        host.cyc(4);
        host.pins(1'b1, 1'b1);
        host.cyc(5);
        check(b(converting), b(1'b1));
        check(b(sdo_oe), b(1'b0));
        host.conv_wait();
        check(b(sdo_oe), b(1'b0));
        check(b(powered_down), b(1'b1));
        host.pins(1'b0, 1'b1);
        host.cyc(10);
        check(b(sdo_oe), b(1'b1));
        host.shift(18, v);
        check(v[17:0], clamp(raw));
        check(b(sdo_oe), b(1'b0));
        $display("three-wire plain readout done");
    endtask

    task automatic t_busy;
        raw = -20'sh80000;
        host.pins(1'b1, 1'b1);
        host.cyc(2);
        host.pins(1'b0, 1'b1);
        host.cyc(3);
        check(b(sdo_oe), b(1'b0));
        host.conv_wait();
        check(b(sdo_oe), b(1'b1));
        check(b(serial_data_out), b(1'b0));
        host.shift(19, v);
        check(b(v[18]), b(1'b0));
        check(v[17:0], clamp(raw));
        check(b(sdo_oe), b(1'b0));
        $display("three-wire busy readout done");
    endtask

    task automatic t_four;
        raw = 20'sh0A5A5;
        host.pins(1'b1, 1'b1);
        host.conv_wait();
        check(b(sdo_oe), b(1'b0));
        host.pins(1'b1, 1'b0);
        host.cyc(10);
        check(b(sdo_oe), b(1'b1));
        host.shift(5, v);
        check({13'h0000, v[4:0]}, clamp(raw) >> 13);
        host.pins(1'b1, 1'b1);
        host.cyc(6);
        check(b(sdo_oe), b(1'b0));
        host.pins(1'b0, 1'b0);
        host.cyc(10);
        check(b(sdo_oe), b(1'b1));
        check(b(serial_data_out), b(1'b0));
        $display("four-wire early release done");
    endtask

    // Select tied to convert; serial clock level sets the busy bit
    task automatic t_chain;
        raw = 20'sh00123;
        for (int k = 0; k < 2; k++) begin
            host.sclk_level(k[0]);
            // Clock level must settle before the convert rise
            host.cyc(4);
            host.pins(1'b1, 1'b1);
            host.cyc(5);
            check(b(converting), b(1'b1));
            host.sclk_level(1'b0);
            host.conv_wait();
            check(b(sdo_oe), b(1'b1));
            check(b(serial_data_out), b(k[0] ? 1'b1 : raw[17]));
            host.pins(1'b0, 1'b0);
            host.cyc(10);
            check(b(serial_data_out), b(1'b0));
        end
        $display("chain mode start done");
    endtask

    task automatic test_done;
        $display("Checks %0d, mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        repeat (2) @(posedge clk);
        #1;
        rst_n = 1'b1;
        host.cyc(8);
        check(b(powered_down), b(1'b1));
        check(b(sdo_oe), b(1'b1));
        t_plain();
        t_busy();
        t_four();
        t_chain();
        test_done();
    end

    // Whole run is about a thousand cycles; this leaves ample margin
    initial begin
        #100000;
        n_mismatch++;
        $display("Error at %0t: watchdog expired", $time);
        test_done();
    end
endmodule
